// >>> src/sscm_pin_mux.sv
`timescale 1ns/10ps
`include "sscm_defs.svh"

// Operation
// - strap low at reset gives the I/O bits, strap high gives chip-selects.
// - function is latched at reset release and kept until next reset.
// - I/O function starts with every bit as input after reset.
// - chip-select pins float in reset, then drive 1 (inactive).
// - all three pins float while reset is low.
// - selects zero, one, two each assert only for their own space.
// - pins float while hold request puts the device in hold.
// - memory clocks keep toggling in hold unless float-in-hold bit is 1.
// - pins float in OFF mode: test reset 0, emu zero 1, emu one/off 0.
// - bus holder per pin, enabled by default, software may switch it.
module sscm_pin_mux (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    // strap
    input  wire logic                 function_strap_pin,
    // float conditions
    input  wire sscm_pkg::sscm_float_t float_ctl,
    // general-purpose I/O from the parallel port logic
    input  wire logic [2:0]           gpio_dir_out,
    input  wire logic [2:0]           gpio_out,
    input  wire logic                 gpio_dir_we,
    input  wire logic [2:0]           gpio_dir_wdata,
    output logic [2:0]                gpio_in,
    // memory interface access
    input  wire logic                 mem_access,
    input  wire logic [1:0]           mem_space,
    // control register bits
    input  wire logic                 holder_we,
    input  wire logic                 holder_wdata,
    input  wire logic [1:0]           clock_out_float_in_hold,
    // pins: parallel_io_bit_a/b/c or mem_space_select_zero/one/two
    input  wire logic [2:0]           pin_i,
    output logic [2:0]                pin_o,
    output logic [2:0]                pin_oe_b,
    output logic [2:0]                pin_holder_en,
    output logic [1:0]                mem_clock_output,
    output logic [1:0]                mem_clock_output_oe_b,
    // status
    output logic                      cs_function,
    output logic [2:0]                gpio_dir
);

    sscm_pkg::sscm_mode_t  mode;
    sscm_pkg::sscm_drive_t req;
    logic                  in_hold;
    logic                  in_off;
    logic                  pins_float;
    logic [2:0]            cs_hit;
    logic [2:0]            next_pin_o;
    logic [2:0]            next_pin_oe_b;
    logic [2:0]            next_gpio_dir;
    logic                  holder_en;

    function automatic logic [2:0] space_decode(input logic acc, input logic [1:0] sp);
        space_decode = 3'h0;
        if (acc && sp == `SSCM_SPACE_ZERO) space_decode = 3'h1;
        if (acc && sp == `SSCM_SPACE_ONE)  space_decode = 3'h2;
        if (acc && sp == `SSCM_SPACE_TWO)  space_decode = 3'h4;
    endfunction

    assign in_hold    = float_ctl.hold_req;
    // off mode decode
    assign in_off     = ~float_ctl.trst_b & float_ctl.emulation_pin_zero
                        & ~float_ctl.emulation_one_off_pin;
    assign pins_float = in_hold | in_off;
    assign cs_hit     = space_decode(mem_access, mem_space);

    // chip-selects are active low, idle at 1
    assign req.value = (mode == sscm_pkg::SSCM_FUNC_CS) ? ~cs_hit : gpio_out;
    assign req.drive = (mode == sscm_pkg::SSCM_FUNC_CS) ? 3'h7 :
                       (mode == sscm_pkg::SSCM_FUNC_GPIO) ? gpio_dir : 3'h0;

    assign next_pin_o    = req.value;
    assign next_pin_oe_b = pins_float ? 3'h7 : ~req.drive;
    assign next_gpio_dir = gpio_dir_we ? gpio_dir_wdata : gpio_dir;

    // mode leaves reset state only at release; strap taken there
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mode <= sscm_pkg::SSCM_IN_RESET;
        end else if (mode == sscm_pkg::SSCM_IN_RESET) begin
            mode <= function_strap_pin ? sscm_pkg::SSCM_FUNC_CS
                                       : sscm_pkg::SSCM_FUNC_GPIO;
        end
    end

    // directions reset to inputs
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            gpio_dir <= `SSCM_GPIO_DIR_RST;
        end else begin
            gpio_dir <= next_gpio_dir | (gpio_dir_out & 3'h0);
        end
    end

    // pins float during reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pin_o    <= {`SSCM_NUM_PINS{`SSCM_CS_INACTIVE}};
            pin_oe_b <= 3'h7;
        end else begin
            pin_o    <= next_pin_o;
            pin_oe_b <= next_pin_oe_b;
        end
    end

    // bus holder enabled by default
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            holder_en <= `SSCM_HOLDER_RESET;
        end else if (holder_we) begin
            holder_en <= holder_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pin_holder_en <= {`SSCM_NUM_PINS{`SSCM_HOLDER_RESET}};
            gpio_in       <= 3'h0;
            cs_function   <= 1'h0;
        end else begin
            pin_holder_en <= {`SSCM_NUM_PINS{holder_en}};
            gpio_in       <= (mode == sscm_pkg::SSCM_FUNC_GPIO) ? pin_i : 3'h0;
            cs_function   <= (mode == sscm_pkg::SSCM_FUNC_CS);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `SSCM_NUM_CLKS; gi = gi + 1) begin : g_clk
            sscm_clk_out u_clk (
                .sys_clk                 (sys_clk),
                .rst_b                   (rst_b),
                .in_hold                 (in_hold),
                .in_off                  (in_off),
                .clock_out_float_in_hold (clock_out_float_in_hold[gi]),
                .clk_o                   (mem_clock_output[gi]),
                .clk_oe_b                (mem_clock_output_oe_b[gi])
            );
        end
    endgenerate

endmodule

// >>> src/sscm_defs.svh
`ifndef SSCM_DEFS_SVH
`define SSCM_DEFS_SVH

`define SSCM_NUM_PINS      3
`define SSCM_NUM_CLKS      2
`define SSCM_CS_INACTIVE   1'h1
`define SSCM_SPACE_ZERO    2'h0
`define SSCM_SPACE_ONE     2'h1
`define SSCM_SPACE_TWO     2'h2
`define SSCM_HOLDER_RESET  1'h1
`define SSCM_GPIO_DIR_RST  3'h0
`define SSCM_CLK_DIV_HALF  4'h1

`endif

// >>> src/sscm_pkg.sv
package sscm_pkg;

    typedef enum logic [1:0] {
        SSCM_IN_RESET,
        SSCM_FUNC_GPIO,
        SSCM_FUNC_CS
    } sscm_mode_t;

    // per-pin drive request before the global float conditions
    typedef struct packed {
        logic [2:0] value;
        logic [2:0] drive;
    } sscm_drive_t;

    // test and hold conditions that force the pins to float
    typedef struct packed {
        logic trst_b;
        logic emulation_pin_zero;
        logic emulation_one_off_pin;
        logic hold_req;
    } sscm_float_t;

endpackage

// >>> src/sscm_clk_out.sv
`timescale 1ns/10ps
`include "sscm_defs.svh"

// one memory clock output: divides sys_clk, floats in hold if asked
module sscm_clk_out (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // control
    input  wire logic in_hold,
    input  wire logic in_off,
    input  wire logic clock_out_float_in_hold,
    // pin
    output logic      clk_o,
    output logic      clk_oe_b
);

    logic next_clk;
    logic next_oe_b;

    assign next_clk  = ~clk_o;
    // toggles through hold unless told to float
    assign next_oe_b = in_off | (in_hold & clock_out_float_in_hold);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            clk_o    <= 1'h0;
            clk_oe_b <= 1'h1;
        end else begin
            clk_o    <= next_clk;
            clk_oe_b <= next_oe_b;
        end
    end

endmodule

// >>> bench/sscm_pin_mux_properties.sv
`timescale 1ns/10ps
module sscm_pin_mux_chk (
    // clock, reset and inputs
    input wire logic                  sys_clk, rst_b, mem_access,
    input wire sscm_pkg::sscm_float_t float_ctl,
    input wire logic [1:0]            mem_space, clock_out_float_in_hold,
    input wire logic [2:0]            gpio_out,
    // outputs
    input wire logic [2:0]            pin_o, pin_oe_b, pin_holder_en, gpio_dir,
    input wire logic [1:0]            mem_clock_output, mem_clock_output_oe_b,
    input wire logic                  cs_function
);
    wire       off = !float_ctl.trst_b && float_ctl.emulation_pin_zero
                     && !float_ctl.emulation_one_off_pin;
    wire       run = !off && !float_ctl.hold_req;
    wire [2:0] cs_exp = (mem_access && mem_space != 2'h3) ? ~(3'h1 << mem_space) : 3'h7;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_live; rst_b [*3]; endsequence
    a_reset_float: assert property (disable iff (1'b0)
        !rst_b |=> pin_oe_b == 3'h7 && pin_holder_en == 3'h7 && gpio_dir == 3'h0)
        else $error("bad reset state");
    a_hold_float: assert property (float_ctl.hold_req |=> pin_oe_b == 3'h7)
        else $error("pins driven in hold");
    a_off_float: assert property (off |=> pin_oe_b == 3'h7 && mem_clock_output_oe_b == 2'h3)
        else $error("pins driven in off mode");
    a_clk_hold: assert property (float_ctl.hold_req && !off
        |=> mem_clock_output_oe_b == $past(clock_out_float_in_hold)) else $error("bad clock float");
    a_clk_toggle: assert property (mem_clock_output_oe_b == 2'h0
        && $past(mem_clock_output_oe_b) == 2'h0 |-> mem_clock_output == ~$past(mem_clock_output))
        else $error("clock output stalled");
    a_mode_fixed: assert property (s_live ##1 rst_b |-> $stable(cs_function))
        else $error("function changed after reset");
    a_cs_decode: assert property (s_live ##0 cs_function && run
        |=> pin_oe_b == 3'h0 && pin_o == $past(cs_exp)) else $error("bad chip select");
    a_gpio_drive: assert property (s_live ##0 !cs_function && run
        |=> (pin_o & ~pin_oe_b) == ($past(gpio_out) & ~pin_oe_b)) else $error("bad io drive");
endmodule

bind sscm_pin_mux sscm_pin_mux_chk chk_u (.sys_clk, .rst_b, .mem_access, .float_ctl,
    .mem_space, .clock_out_float_in_hold, .gpio_out, .pin_o, .pin_oe_b, .pin_holder_en,
    .gpio_dir, .mem_clock_output, .mem_clock_output_oe_b, .cs_function);

// >>> bench/sscm_board.sv
`timescale 1ns/10ps
// strap wiring and pin loads on the board
module sscm_board (
    input  wire logic       sys_clk, rst_b, strap_level,
    input  wire logic [2:0] pin_o, pin_oe_b, pin_holder_en,
    output logic            function_strap_pin,
    output logic [2:0]      pin_i
);
    logic [1:0] up = 2'h0;
    logic       wig = 1'h0;
    logic [2:0] kept = 3'h0;
    // strap held through reset, then reused as a toggling line
    assign function_strap_pin = up[1] ? wig : strap_level;
    // floating pins keep their level with the holder, else wander
    assign pin_i = (~pin_oe_b & pin_o) | (pin_oe_b & pin_holder_en & kept)
                 | (pin_oe_b & ~pin_holder_en & {3{wig}});
    always_ff @(posedge sys_clk) begin
        up <= rst_b ? {up[0], 1'h1} : 2'h0;
        wig <= ~wig;
        kept <= pin_i;
    end
endmodule

// >>> bench/tb_sscm_pin_mux.sv
`timescale 1ns/10ps
module tb_sscm_pin_mux;
    logic sys_clk = 1'h0, rst_b = 1'h0, strap = 1'h0, function_strap_pin, cs_function;
    logic gpio_dir_we = 1'h0, mem_access = 1'h0, holder_we = 1'h0, holder_wdata = 1'h0;
    logic [2:0] gpio_out = 3'h0, gpio_dir_wdata = 3'h0, pin_i, pin_o, pin_oe_b;
    logic [2:0] pin_holder_en, gpio_in, gpio_dir;
    logic [1:0] mem_space = 2'h0, clock_out_float_in_hold = 2'h0;
    logic [1:0] mem_clock_output, mem_clock_output_oe_b;
    logic [31:0] seed = 32'h1597, r;
    sscm_pkg::sscm_float_t float_ctl = 4'h8;
    int failures = 0, n_tests = 0;
    sscm_pin_mux dut_u (.sys_clk, .rst_b, .function_strap_pin, .float_ctl,
        .gpio_dir_out(3'h0), .gpio_out, .gpio_dir_we, .gpio_dir_wdata, .gpio_in,
        .mem_access, .mem_space, .holder_we, .holder_wdata, .clock_out_float_in_hold,
        .pin_i, .pin_o, .pin_oe_b, .pin_holder_en, .mem_clock_output,
        .mem_clock_output_oe_b, .cs_function, .gpio_dir);
    sscm_board board_u (.sys_clk, .rst_b, .strap_level(strap), .pin_o, .pin_oe_b,
        .pin_holder_en, .function_strap_pin, .pin_i);
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic step();
        @(posedge sys_clk);
        #2;
    endtask
    task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
        n_tests++;
        if (e !== g) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rst(logic s);
        rst_b = 1'h0;
        strap = s;
        repeat (16) step();
        chk("pin_oe_b", 3'h7, pin_oe_b);
        chk("pin_holder_en", 3'h7, pin_holder_en);
        rst_b = 1'h1;
        repeat (2) step();
        chk("cs_function", {2'h0, s}, {2'h0, cs_function});
        chk("pin_oe_b", s ? 3'h0 : 3'h7, pin_oe_b);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        rst(1'h0);
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            gpio_dir_wdata = r[2:0];
            gpio_out = r[5:3];
            gpio_dir_we = 1'h1;
            holder_wdata = r[6];
            holder_we = 1'h1;
            step();
            gpio_dir_we = 1'h0;
            holder_we = 1'h0;
            repeat (2) step();
            chk("gpio_dir", r[2:0], gpio_dir);
            chk("pin_oe_b", ~r[2:0], pin_oe_b);
            chk("gpio_in", r[5:3] & r[2:0], gpio_in & r[2:0]);
            chk("pin_holder_en", {3{r[6]}}, pin_holder_en);
        end
        rst(1'h1);
        for (int i = 0; i < 8; i++) begin
            mem_access = i[2];
            mem_space = i[1:0];
            repeat (2) step();
            chk("pin_o", (i[2] && i[1:0] != 3) ? ~(3'h1 << i[1:0]) : 3'h7, pin_o);
            chk("gpio_in", 3'h0, gpio_in);
        end
        for (int i = 0; i < 5; i++) begin
            clock_out_float_in_hold = i[1:0];
            float_ctl = (i < 4) ? 4'h9 : 4'h4;
            repeat (2) step();
            chk("pin_oe_b", 3'h7, pin_oe_b);
            chk("clk_oe_b", (i < 4) ? {1'h0, i[1:0]} : 3'h3, {1'h0, mem_clock_output_oe_b});
        end
        float_ctl = 4'h8;
        mem_access = 1'h0;
        repeat (2) step();
        chk("pin_o", 3'h7, pin_o);
        chk("cs_function", 3'h1, {2'h0, cs_function});
        r[1:0] = mem_clock_output;
        step();
        chk("mem_clock_output", {1'h0, ~r[1:0]}, {1'h0, mem_clock_output});
        print_verdict();
    end
endmodule
